//--- rtl/fpc_cmp.v
// Single-cycle compare, minimum, maximum, negate and absolute value
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.vh"
module fpc_cmp #(
  parameter EN_ARITH = 1,
  parameter EN_CMP = 1
) (
  input wire [7:0] sel_in,
  input wire [31:0] op_a_in,
  input wire [31:0] op_b_in,
  output reg [31:0] result_out
);
  function is_nan(input [31:0] x);
    is_nan = (x[30:23] == `FPC_EXP_MAX) && |x[22:0];
  endfunction
  // Exact ordering, subnormals kept, either zero equal
  function less(input [31:0] x, input [31:0] y);
    if (is_nan(x) || is_nan(y) || (x[30:0] == 31'h0 && y[30:0] == 31'h0))
      less = 1'b0;
    else if (x[31] != y[31])
      less = x[31];
    else
      less = x[31] ? (x[30:0] > y[30:0]) : (x[30:0] < y[30:0]);
  endfunction
  function same(input [31:0] x, input [31:0] y);
    if (is_nan(x) || is_nan(y))
      same = 1'b0;
    else
      same = (x == y) || (x[30:0] == 31'h0 && y[30:0] == 31'h0);
  endfunction
  wire lt = less(op_a_in, op_b_in);
  wire gt = less(op_b_in, op_a_in);
  wire eq = same(op_a_in, op_b_in);
  always @* begin
    result_out = `FPC_RESULT_RST;
    if (EN_CMP != 0) begin
      case (sel_in)
        `FPC_SEL_MIN: result_out = lt ? op_a_in : op_b_in;
        `FPC_SEL_MAX: result_out = lt ? op_b_in : op_a_in;
        `FPC_SEL_LT: result_out = {31'h0, lt};
        `FPC_SEL_LE: result_out = {31'h0, lt | eq};
        `FPC_SEL_GT: result_out = {31'h0, gt};
        `FPC_SEL_GE: result_out = {31'h0, gt | eq};
        `FPC_SEL_EQ: result_out = {31'h0, eq};
        `FPC_SEL_NE: result_out = {31'h0, ~eq};
        default: result_out = `FPC_RESULT_RST;
      endcase
    end
    if (EN_ARITH != 0 && sel_in == `FPC_SEL_NEG)
      result_out = {~op_a_in[31], op_a_in[30:0]};
    if (EN_ARITH != 0 && sel_in == `FPC_SEL_ABS)
      result_out = {1'b0, op_a_in[30:0]};
  end
endmodule
`default_nettype wire

//--- rtl/fpc_consts.vh
// Selector codes, latencies and encodings of the floating-point custom unit
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
`define FPC_SEL_BASE 8'he0
`define FPC_SEL_DIV 8'hff
`define FPC_SEL_SUB 8'hfe
`define FPC_SEL_ADD 8'hfd
`define FPC_SEL_MUL 8'hfc
`define FPC_SEL_SQRT 8'hfb
`define FPC_SEL_ITOF 8'hfa
`define FPC_SEL_FTOI_TRUNC 8'hf9
`define FPC_SEL_FTOI_ROUND 8'hf8
`define FPC_SEL_RSV_HI 8'hf7
`define FPC_SEL_RSV_LO 8'hea
`define FPC_SEL_MIN 8'he9
`define FPC_SEL_MAX 8'he8
`define FPC_SEL_LT 8'he7
`define FPC_SEL_LE 8'he6
`define FPC_SEL_GT 8'he5
`define FPC_SEL_GE 8'he4
`define FPC_SEL_EQ 8'he3
`define FPC_SEL_NE 8'he2
`define FPC_SEL_NEG 8'he1
`define FPC_SEL_ABS 8'he0
`define FPC_LAT_DIV 5'h10
`define FPC_LAT_ADDSUB 5'h05
`define FPC_LAT_MUL 5'h04
`define FPC_LAT_SQRT 5'h08
`define FPC_LAT_ITOF 5'h04
`define FPC_LAT_FTOI 5'h02
`define FPC_LAT_MAX 5'h10
`define FPC_QNAN 32'h7fc00000
`define FPC_INT_MIN 32'h80000000
`define FPC_INT_MAX 32'h7fffffff
`define FPC_EXP_MAX 8'hff
`define FPC_BIAS 8'h7f
`define FPC_RESULT_RST 32'h00000000
`endif

//--- rtl/fpc_conv.v
// Integer to float and float to integer conversions, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.vh"
module fpc_conv (
  input wire [31:0] op_a_in,
  output reg [31:0] itof_out,
  output reg [31:0] trunc_out,
  output reg [31:0] round_out
);
  reg [31:0] mag;
  reg [31:0] nrm;
  reg [7:0] ex;
  reg [32:0] fx;
  reg [32:0] rnd;
  integer k;
  always @* begin
    // Integer to float: never subnormal, low bits truncated
    mag = op_a_in[31] ? (32'h0 - op_a_in) : op_a_in;
    nrm = mag;
    ex = 8'h9e;
    for (k = 0; k < 31; k = k + 1) begin
      if (!nrm[31] && nrm != 32'h0) begin
        nrm = nrm << 1;
        ex = ex - 8'h01;
      end
    end
    itof_out = (mag == 32'h0) ? 32'h0 : {op_a_in[31], ex, nrm[30:8]};
    // Float to integer with one fraction bit kept for the half
    ex = op_a_in[30:23];
    if (ex >= 8'h95)
      fx = {9'h0, |ex, op_a_in[22:0]} << (ex - 8'h95);
    else if (ex < 8'h75)
      fx = 33'h0;
    else
      fx = {9'h0, |ex, op_a_in[22:0]} >> (8'h95 - ex);
    rnd = {1'b0, fx[32:1]} + {32'h0, fx[0]};
    if (ex == `FPC_EXP_MAX && |op_a_in[22:0]) begin
      trunc_out = `FPC_INT_MIN;
      round_out = `FPC_INT_MIN;
    end else if (ex >= 8'h9e) begin
      trunc_out = op_a_in[31] ? `FPC_INT_MIN : `FPC_INT_MAX;
      round_out = trunc_out;
    end else begin
      trunc_out = op_a_in[31] ? (32'h0 - fx[32:1]) : fx[32:1];
      if (rnd[31] && !op_a_in[31])
        round_out = `FPC_INT_MAX;
      else
        round_out = op_a_in[31] ? (32'h0 - rnd[31:0]) : rnd[31:0];
    end
  end
endmodule
`default_nettype wire

//--- rtl/fpc_unit.v
// Single-precision floating-point custom-instruction execution unit, top level
// What this block does
// - Decode an 8-bit selector; operations use values 224 through 255.
// - Selectors 252 to 255 keep the earlier generation's operations.
// - 255 divides a by b in 16 cycles, nearest rounding, flush-to-zero.
// - 254 subtracts, 253 adds, 5 cycles, faithful rounding, flush-to-zero.
// - 252 multiplies in 4 cycles, faithful rounding, flush-to-zero.
// - 251 takes square root of a in 8 cycles, faithful, flush-to-zero.
// - 250 converts signed integer a to float in 4 cycles, never subnormal.
// - 249 converts float a to integer in 2 cycles, truncating toward zero.
// - 248 converts float a to integer in 2 cycles, rounding to nearest.
// - Single-cycle ops are combinational; N-cycle ops hold N-2 register stages.
// - No traps, exceptions or status flags; always a defined result.
// - Invalid gives NaN, overflow or divide-by-zero infinity, underflow zero.
// - Arithmetic and root treat subnormals as signed zero, both ways.
// - Compare, min, max, float-to-int, negate, absolute handle subnormals exactly.
// - No signalling versus quiet NaN distinction; arithmetic and root return one fixed NaN.
// - No round-to-nearest-even; each operator has its fixed scheme.
// - Operation groups can be left out at build time; all included by default.
// - Operands and results are 32-bit words.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.vh"
module fpc_unit #(
  parameter EN_ARITH = 1,
  parameter EN_ROOT = 1,
  parameter EN_CONV = 1,
  parameter EN_CMP = 1
) (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire start_in,
  input wire [7:0] sel_in,
  input wire [31:0] dataa_in,
  input wire [31:0] datab_in,
  output reg [31:0] result_out,
  output reg done_out,
  output wire [31:0] comb_result_out
);
  localparam integer NST = `FPC_LAT_MAX - 2;

  function is_nan(input [31:0] x);
    is_nan = (x[30:23] == `FPC_EXP_MAX) && |x[22:0];
  endfunction

  function is_inf(input [31:0] x);
    is_inf = (x[30:23] == `FPC_EXP_MAX) && ~|x[22:0];
  endfunction

  // Zero or subnormal, both read as zero here
  function is_z(input [31:0] x);
    is_z = ~|x[30:23];
  endfunction

  // Overflow to infinity, underflow to signed zero
  function [31:0] pack(input s, input signed [9:0] e, input [22:0] f);
    if (e >= 10'sd255)
      pack = {s, `FPC_EXP_MAX, 23'h0};
    else if (e <= 10'sd0)
      pack = {s, 31'h0};
    else
      pack = {s, e[7:0], f};
  endfunction

  function [31:0] fp_add(input [31:0] a, input [31:0] b);
    reg [31:0] x;
    reg [31:0] y;
    reg [31:0] t;
    reg [26:0] mx;
    reg [26:0] my;
    reg [27:0] s;
    reg signed [9:0] e;
    reg [7:0] d;
    integer k;
    begin
      x = is_z(a) ? {a[31], 31'h0} : a;
      y = is_z(b) ? {b[31], 31'h0} : b;
      if (x[30:0] < y[30:0]) begin
        t = x;
        x = y;
        y = t;
      end
      mx = {|x[30:23], x[22:0], 3'b000};
      my = {|y[30:23], y[22:0], 3'b000};
      d = x[30:23] - y[30:23];
      // Three guard bits plus sticky keep truncation faithful
      if (d > 8'd26)
        my = {26'h0, |my};
      else
        my = (my >> d) | {26'h0, |(my & ~({27{1'b1}} << d))};
      if (x[31] == y[31])
        s = {1'b0, mx} + {1'b0, my};
      else
        s = {1'b0, mx} - {1'b0, my};
      e = {2'b00, x[30:23]};
      if (s[27]) begin
        s = s >> 1;
        e = e + 10'sd1;
      end
      for (k = 0; k < 27; k = k + 1) begin
        if (!s[26] && s != 28'h0) begin
          s = s << 1;
          e = e - 10'sd1;
        end
      end
      if (is_nan(a) || is_nan(b) || (is_inf(a) && is_inf(b) && a[31] != b[31]))
        fp_add = `FPC_QNAN;
      else if (is_inf(a))
        fp_add = a;
      else if (is_inf(b))
        fp_add = b;
      else if (s == 28'h0)
        fp_add = {x[31] & y[31], 31'h0};
      else
        fp_add = pack(x[31], e, s[25:3]);
    end
  endfunction

  function [31:0] fp_mul(input [31:0] a, input [31:0] b);
    reg [47:0] p;
    reg signed [9:0] e;
    reg s;
    begin
      s = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - {2'b00, `FPC_BIAS};
      if (p[47]) begin
        p = p >> 1;
        e = e + 10'sd1;
      end
      if (is_nan(a) || is_nan(b) || (is_inf(a) && is_z(b)) || (is_inf(b) && is_z(a)))
        fp_mul = `FPC_QNAN;
      else if (is_inf(a) || is_inf(b))
        fp_mul = {s, `FPC_EXP_MAX, 23'h0};
      else if (is_z(a) || is_z(b))
        fp_mul = {s, 31'h0};
      else
        fp_mul = pack(s, e, p[45:23]);
    end
  endfunction

  function [31:0] fp_div(input [31:0] a, input [31:0] b);
    reg [49:0] q;
    reg [24:0] m;
    reg signed [9:0] e;
    reg s;
    begin
      s = a[31] ^ b[31];
      q = {1'b1, a[22:0], 26'h0} / {26'h0, 1'b1, b[22:0]};
      e = {2'b00, a[30:23]} - {2'b00, b[30:23]} + {2'b00, `FPC_BIAS};
      // Round half up on the first dropped bit
      if (q[26]) begin
        m = {1'b0, q[26:3]} + {24'h0, q[2]};
      end else begin
        m = {1'b0, q[25:2]} + {24'h0, q[1]};
        e = e - 10'sd1;
      end
      if (m[24]) begin
        m = m >> 1;
        e = e + 10'sd1;
      end
      if (is_nan(a) || is_nan(b) || (is_z(a) && is_z(b)) || (is_inf(a) && is_inf(b)))
        fp_div = `FPC_QNAN;
      else if (is_inf(a) || is_z(b))
        fp_div = {s, `FPC_EXP_MAX, 23'h0};
      else if (is_z(a) || is_inf(b))
        fp_div = {s, 31'h0};
      else
        fp_div = pack(s, e, m[22:0]);
    end
  endfunction

  function [31:0] fp_sqrt(input [31:0] a);
    reg [47:0] r;
    reg [23:0] rt;
    reg [23:0] t;
    reg [8:0] e;
    reg odd;
    integer k;
    begin
      odd = ~a[23];
      if (odd)
        r = {1'b1, a[22:0], 24'h0};
      else
        r = {1'b0, 1'b1, a[22:0], 23'h0};
      rt = 24'h0;
      // Bitwise root, remainder dropped, so within one unit
      for (k = 23; k >= 0; k = k - 1) begin
        t = rt | (24'h1 << k);
        if (t * t <= r)
          rt = t;
      end
      e = ({1'b0, a[30:23]} + {1'b0, `FPC_BIAS} - {8'h0, odd}) >> 1;
      if (is_nan(a) || (a[31] && !is_z(a)))
        fp_sqrt = `FPC_QNAN;
      else if (is_z(a))
        fp_sqrt = {a[31], 31'h0};
      else if (is_inf(a))
        fp_sqrt = a;
      else
        fp_sqrt = {1'b0, e[7:0], rt[22:0]};
    end
  endfunction

  wire [31:0] itof_w;
  wire [31:0] trunc_w;
  wire [31:0] round_w;
  wire [31:0] cmp_w;

  fpc_conv u_conv (
    .op_a_in(dataa_in),
    .itof_out(itof_w),
    .trunc_out(trunc_w),
    .round_out(round_w)
  );

  fpc_cmp #(
    .EN_ARITH(EN_ARITH),
    .EN_CMP(EN_CMP)
  ) u_cmp (
    .sel_in(sel_in),
    .op_a_in(dataa_in),
    .op_b_in(datab_in),
    .result_out(cmp_w)
  );

  // Combinational path straight to the processor
  assign comb_result_out = cmp_w;

  reg [31:0] mc_res;
  reg [4:0] mc_lat;

  // Multi-cycle selector decode; absent groups and reserved codes start nothing
  always @* begin
    mc_res = `FPC_RESULT_RST;
    mc_lat = 5'h00;
    case (sel_in)
      `FPC_SEL_DIV: begin
        if (EN_ARITH != 0) begin
          mc_res = fp_div(dataa_in, datab_in);
          mc_lat = `FPC_LAT_DIV;
        end
      end
      `FPC_SEL_SUB: begin
        if (EN_ARITH != 0) begin
          mc_res = fp_add(dataa_in, {~datab_in[31], datab_in[30:0]});
          mc_lat = `FPC_LAT_ADDSUB;
        end
      end
      `FPC_SEL_ADD: begin
        if (EN_ARITH != 0) begin
          mc_res = fp_add(dataa_in, datab_in);
          mc_lat = `FPC_LAT_ADDSUB;
        end
      end
      `FPC_SEL_MUL: begin
        if (EN_ARITH != 0) begin
          mc_res = fp_mul(dataa_in, datab_in);
          mc_lat = `FPC_LAT_MUL;
        end
      end
      `FPC_SEL_SQRT: begin
        if (EN_ROOT != 0) begin
          mc_res = fp_sqrt(dataa_in);
          mc_lat = `FPC_LAT_SQRT;
        end
      end
      `FPC_SEL_ITOF: begin
        if (EN_CONV != 0) begin
          mc_res = itof_w;
          mc_lat = `FPC_LAT_ITOF;
        end
      end
      `FPC_SEL_FTOI_TRUNC: begin
        if (EN_CONV != 0) begin
          mc_res = trunc_w;
          mc_lat = `FPC_LAT_FTOI;
        end
      end
      `FPC_SEL_FTOI_ROUND: begin
        if (EN_CONV != 0) begin
          mc_res = round_w;
          mc_lat = `FPC_LAT_FTOI;
        end
      end
      default: begin
        mc_res = `FPC_RESULT_RST;
        mc_lat = 5'h00;
      end
    endcase
  end

  wire go = start_in && (mc_lat != 5'h00);
  // Entry stage so the word crosses exactly lat-2 stages
  wire [4:0] ins_idx = `FPC_LAT_MAX - mc_lat;

  reg [31:0] stg_res_r [0:NST-1];
  reg [NST-1:0] stg_vld_r;
  integer i;

  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      stg_vld_r <= {NST{1'b0}};
      for (i = 0; i < NST; i = i + 1) begin
        stg_res_r[i] <= `FPC_RESULT_RST;
      end
    end else begin
      if (go && ins_idx == 5'h00) begin
        stg_vld_r[0] <= 1'b1;
        stg_res_r[0] <= mc_res;
      end else begin
        stg_vld_r[0] <= 1'b0;
      end
      for (i = 1; i < NST; i = i + 1) begin
        if (go && ins_idx == i) begin
          stg_vld_r[i] <= 1'b1;
          stg_res_r[i] <= mc_res;
        end else begin
          stg_vld_r[i] <= stg_vld_r[i-1];
          stg_res_r[i] <= stg_res_r[i-1];
        end
      end
    end
  end

  // Last register stands in for the processor's own result register
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      result_out <= `FPC_RESULT_RST;
      done_out <= 1'b0;
    end else if (go && ins_idx == NST) begin
      result_out <= mc_res;
      done_out <= 1'b1;
    end else begin
      done_out <= stg_vld_r[NST-1];
      if (stg_vld_r[NST-1])
        result_out <= stg_res_r[NST-1];
    end
  end
endmodule
`default_nettype wire

//--- verif/fpc_proc_model.sv
// Processor side of the custom-instruction port
`timescale 1ns/1ps
`default_nettype none
module fpc_proc_model (
  input wire logic sys_clk_in,
  input wire logic done_in,
  input wire logic [31:0] result_in,
  input wire logic [31:0] comb_in,
  output logic start_out,
  output logic [7:0] sel_out,
  output logic [31:0] dataa_out,
  output logic [31:0] datab_out
);
  initial begin
    start_out = 1'b0;
    sel_out = 8'h00;
    dataa_out = 32'h0;
    datab_out = 32'h0;
  end
  task automatic op(input logic [7:0] s, input logic [31:0] a, input logic [31:0] b,
    output logic [31:0] r, output int lat);
    int n;
    start_out = 1'b1;
    sel_out = s;
    dataa_out = a;
    datab_out = b;
    @(posedge sys_clk_in);
    #1;
    start_out = 1'b0;
    // Released lines show the inverse, not a stale copy
    sel_out = ~sel_out;
    dataa_out = ~dataa_out;
    datab_out = ~datab_out;
    n = 2;
    while (done_in !== 1'b1 && n < 40) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    lat = (done_in === 1'b1) ? n : 0;
    r = result_in;
  endtask
  task automatic comb(input logic [7:0] s, input logic [31:0] a, input logic [31:0] b,
    output logic [31:0] r);
    sel_out = s;
    dataa_out = a;
    datab_out = b;
    #2;
    r = comb_in;
    @(posedge sys_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

//--- verif/fpc_unit_assertions.sv
// Port checks of the floating-point custom unit
`timescale 1ns/1ps
`default_nettype none
module fpc_unit_chk (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic [7:0] sel_in,
  input wire logic [31:0] dataa_in,
  input wire logic [31:0] datab_in,
  input wire logic [31:0] result_out,
  input wire logic done_out,
  input wire logic [31:0] comb_result_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  div_lat_a: assert property (start_in && sel_in == 8'hff |=> !done_out [*8] ##7 done_out)
    else $error("divide done off time");
  addsub_lat_a: assert property (start_in && (sel_in == 8'hfe || sel_in == 8'hfd) |=>
    !done_out [*3] ##1 done_out) else $error("add or sub done off time");
  mul_itof_lat_a: assert property (start_in && (sel_in == 8'hfc || sel_in == 8'hfa)
    |-> ##3 done_out) else $error("multiply or int-to-float done off time");
  sqrt_lat_a: assert property (start_in && sel_in == 8'hfb |=> !done_out [*6] ##1 done_out)
    else $error("root done off time");
  ftoi_lat_a: assert property (start_in && sel_in[7:1] == 7'h7c |=> done_out)
    else $error("float-to-int done off time");
  refused_nodone_a: assert property (start_in && sel_in < 8'hf8 |=> !done_out [*8])
    else $error("done after a refused start");
  reset_clear_a: assert property (disable iff (1'b0) !reset_n_in |=>
    !done_out && result_out == 0) else $error("reset left result or done");
  done_pulse_a: assert property (done_out && !(start_in && sel_in[7:1] == 7'h7c)
    |=> !done_out) else $error("done longer than one cycle");
  result_hold_a: assert property (!done_out && $past(reset_n_in) |-> $stable(result_out))
    else $error("result moved without done");
  comb_zero_a: assert property (!(sel_in inside {[8'he0:8'he9]})
    |-> comb_result_out == 0) else $error("comb result not zero");
  neg_comb_a: assert property (sel_in == 8'he1 |->
    comb_result_out == {~dataa_in[31], dataa_in[30:0]}) else $error("negate wrong");
  abs_comb_a: assert property (sel_in == 8'he0 |->
    comb_result_out == {1'b0, dataa_in[30:0]}) else $error("absolute wrong");
  cmp_bool_a: assert property (sel_in inside {[8'he2:8'he7]} |->
    comb_result_out[31:1] == 0) else $error("compare not 0 or 1");
endmodule
bind fpc_unit fpc_unit_chk fpc_unit_chk_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .start_in(start_in), .sel_in(sel_in), .dataa_in(dataa_in), .datab_in(datab_in),
  .result_out(result_out), .done_out(done_out), .comb_result_out(comb_result_out));
`default_nettype wire

//--- verif/fpc_unit_tb.sv
// Self-checking bench of the floating-point custom unit
`timescale 1ns/1ps
`default_nettype none
module fpc_unit_tb;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  wire st, dn;
  wire [7:0] sl;
  wire [31:0] da, db, rs, cr;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int lat;
  logic [31:0] got;
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  fpc_unit fpc_unit_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .start_in(st),
    .sel_in(sl), .dataa_in(da), .datab_in(db), .result_out(rs), .done_out(dn),
    .comb_result_out(cr));
  fpc_proc_model fpc_proc_model_i (.sys_clk_in(sys_clk_in), .done_in(dn), .result_in(rs),
    .comb_in(cr), .start_out(st), .sel_out(sl), .dataa_out(da), .datab_out(db));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic mop(input logic [7:0] s, input logic [31:0] a, b, want, input int l);
    fpc_proc_model_i.op(s, a, b, got, lat);
    check(got, want);
    check(32'(lat), 32'(l));
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic cmb(input logic [7:0] s, input logic [31:0] a, b, want);
    fpc_proc_model_i.comb(s, a, b, got);
    check(got, want);
  endtask
  task automatic t_arith;
    mop(8'hfd, 32'h3f800000, 32'h40000000, 32'h40400000, 5);
    mop(8'hfe, 32'h3f800000, 32'h40000000, 32'hbf800000, 5);
    mop(8'hfc, 32'h40000000, 32'h40400000, 32'h40c00000, 4);
    mop(8'hff, 32'h40c00000, 32'h40000000, 32'h40400000, 16);
    mop(8'hff, 32'h3f800000, 32'h40400000, 32'h3eaaaaab, 16);
    mop(8'hff, 32'h3f800000, 32'h80000000, 32'hff800000, 16);
    mop(8'hfb, 32'h40800000, 32'h0, 32'h40000000, 8);
    mop(8'hfb, 32'hbf800000, 32'h0, 32'h7fc00000, 8);
    mop(8'hfe, 32'h7f800000, 32'h7f800000, 32'h7fc00000, 5);
    mop(8'hfc, 32'h7f000000, 32'h40000000, 32'h7f800000, 4);
    mop(8'hfc, 32'h00800000, 32'h00800000, 32'h0, 4);
    mop(8'hfc, 32'h80400000, 32'h40000000, 32'h80000000, 4);
    mop(8'hfd, 32'h00000001, 32'h3f800000, 32'h3f800000, 5);
    mop(8'hfd, 32'h3f800000, 32'h33c00000, 32'h3f800000, 5);
  endtask
  task automatic t_conv;
    mop(8'hfa, 32'h5, 32'h0, 32'h40a00000, 4);
    mop(8'hfa, 32'hffffffff, 32'h0, 32'hbf800000, 4);
    mop(8'hf9, 32'hc0200000, 32'h0, 32'hfffffffe, 2);
    mop(8'hf8, 32'hc0200000, 32'h0, 32'hfffffffd, 2);
    mop(8'hf8, 32'h3fc00000, 32'h0, 32'h2, 2);
    mop(8'hf9, 32'h00000001, 32'h0, 32'h0, 2);
    mop(8'hf9, 32'h7fc00000, 32'h0, 32'h80000000, 2);
  endtask
  task automatic t_comb;
    logic [5:0] tv;
    tv = 6'b100011;
    cmb(8'he9, 32'h3f800000, 32'h40000000, 32'h3f800000);
    cmb(8'he8, 32'h3f800000, 32'h40000000, 32'h40000000);
    cmb(8'he1, 32'h3f800000, 32'h0, 32'hbf800000);
    cmb(8'he0, 32'hbf800000, 32'h0, 32'h3f800000);
    for (int i = 0; i < 6; i++) begin
      cmb(8'(8'he7 - i), 32'h3f800000, 32'h40000000, {31'h0, tv[i]});
    end
    cmb(8'he3, 32'h0, 32'h80000000, 32'h1);
    cmb(8'he7, 32'h1, 32'h2, 32'h1);
    cmb(8'he1, 32'h1, 32'h0, 32'h80000001);
  endtask
  task automatic t_b2b;
    fpc_proc_model_i.op(8'hfd, 32'h40000000, 32'h40000000, got, lat);
    check(got, 32'h40800000);
    // Next start lands in the done cycle
    fpc_proc_model_i.op(8'hf9, 32'h40400000, 32'h0, got, lat);
    check(got, 32'h3);
    check(32'(lat), 32'h2);
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic t_resv;
    fpc_proc_model_i.op(8'he9, 32'h3f800000, 32'h40000000, got, lat);
    check(32'(lat), 32'h0);
    for (int s = 8'hea; s <= 8'hf7; s++) begin
      fpc_proc_model_i.op(8'(s), 32'h3f800000, 32'h40000000, got, lat);
      check(32'(lat), 32'h0);
      cmb(8'(s), 32'h3f800000, 32'h40000000, 32'h0);
    end
  endtask
  task automatic t_reset;
    fork
      fpc_proc_model_i.op(8'hff, 32'h40000000, 32'h40000000, got, lat);
      begin
        repeat (4) @(posedge sys_clk_in);
        #1;
        reset_n_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        reset_n_in = 1'b1;
      end
    join
    check(32'(lat), 32'h0);
    check(rs, 32'h0);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      results;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    t_arith;
    t_conv;
    t_comb;
    t_b2b;
    t_resv;
    t_reset;
    results;
  end
endmodule
`default_nettype wire
